// ### core/lpc_cmd.sv
// What this block does
// - character count written minus one, code 02
// - time divisions written minus one, code 03
// - each instruction executes four microseconds
// - cursor line minus one, low four bits
// - cursor spans horizontal pitch in character mode
// - cursor dots override character dots
// - no cursor when line exceeds vertical pitch
// - start address low 08, high 09
// - character mode uses twelve start bits
// - cursor address low 0A, high 0B
// - cursor sits at cursor address location
// - sixteen-bit up counter with carry ripple
// - low load falling bit seven bumps high
`include "lpc_params.svh"
module lpc_cmd import lpc_pkg::*; #(
  parameter int EXEC_CYC = `LPC_EXEC_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic register_select,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe,
  input wire logic graphic_mode,
  input wire logic cursor_on,
  input wire logic [2:0] hpitch_m1,
  input wire logic [3:0] vpitch_m1,
  input wire logic cursor_inc,
  input wire logic [15:0] refresh_addr,
  input wire logic [3:0] refresh_line,
  input wire logic [2:0] refresh_dot,
  input wire logic char_dot,
  output logic pixel_out,
  output logic [6:0] hcount_m1,
  output logic [6:0] tdiv_m1,
  output logic [15:0] start_addr,
  output logic [15:0] cursor_addr,
  output logic busy
);
  typedef struct packed {
    lpc_state_t st;
    logic [7:0] code;
    lpc_regs_t regs;
    logic [7:0] dout;
    logic pix;
  } lpc_cmd_state_t;
  lpc_cmd_state_t s_r;
  lpc_cmd_state_t s_nxt;
  logic exec_busy;
  logic start_exec;
  logic carry8;
  logic cursor_hit;
  logic cursor_draw;

  function automatic logic is_param_code(input logic [7:0] c);
    is_param_code = (c == `LPC_CODE_HCOUNT) || (c == `LPC_CODE_TDIV) ||
      (c == `LPC_CODE_CLINE) || (c == `LPC_CODE_START_LO) ||
      (c == `LPC_CODE_START_HI) || (c == `LPC_CODE_CUR_LO) ||
      (c == `LPC_CODE_CUR_HI);
  endfunction : is_param_code

  lpc_exec_timer #(.CYCLES(EXEC_CYC)) u_tmr (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(start_exec),
    .busy(exec_busy)
  );

  assign start_exec = host_wr && !register_select && !exec_busy &&
    is_param_code(s_r.code);
  assign carry8 = s_r.regs.cursor_addr[7] && !host_data_bus_in[7];
  assign cursor_hit = !graphic_mode && (refresh_addr[11:0] == s_r.regs.cursor_addr[11:0]);
  assign cursor_draw = cursor_on && cursor_hit &&
    (s_r.regs.cline[3:0] == refresh_line) && (refresh_dot <= hpitch_m1) &&
    (s_r.regs.cline[3:0] <= vpitch_m1);

  always_comb begin
    s_nxt = s_r;
    s_nxt.pix = cursor_draw ? 1'b1 : char_dot;
    s_nxt.dout = {exec_busy, 7'h00};
    if (host_wr && register_select && !exec_busy) begin
      s_nxt.code = host_data_bus_in;
    end
    if (start_exec) begin
      unique case (s_r.code)
        `LPC_CODE_HCOUNT: s_nxt.regs.hcount = {1'b0, host_data_bus_in[6:0]};
        `LPC_CODE_TDIV: s_nxt.regs.tdiv = {1'b0, host_data_bus_in[6:0]};
        `LPC_CODE_CLINE: s_nxt.regs.cline = {4'h0, host_data_bus_in[3:0]};
        `LPC_CODE_START_LO: s_nxt.regs.start_addr[7:0] = host_data_bus_in;
        `LPC_CODE_START_HI: s_nxt.regs.start_addr[15:8] = host_data_bus_in;
        `LPC_CODE_CUR_LO: begin
          s_nxt.regs.cursor_addr[7:0] = host_data_bus_in;
          s_nxt.regs.cursor_addr[15:8] = s_r.regs.cursor_addr[15:8] + {7'h00, carry8};
        end
        `LPC_CODE_CUR_HI: s_nxt.regs.cursor_addr[15:8] = host_data_bus_in;
        default: s_nxt.regs = s_r.regs;
      endcase
    end else if (cursor_inc && !exec_busy) begin
      s_nxt.regs.cursor_addr = s_r.regs.cursor_addr + 16'h0001;
    end
    unique case (s_r.st)
      LPC_IDLE: begin
        if (start_exec) begin
          s_nxt.st = LPC_EXEC;
        end else if (host_wr && register_select) begin
          s_nxt.st = LPC_CODE;
        end
      end
      LPC_CODE: begin
        if (start_exec) begin
          s_nxt.st = LPC_EXEC;
        end
      end
      LPC_EXEC: begin
        if (start_exec) begin
          s_nxt.st = LPC_EXEC;
        end else if (!exec_busy) begin
          s_nxt.st = (host_wr && register_select) ? LPC_CODE : LPC_IDLE;
        end
      end
      default: begin
        s_nxt.st = LPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.regs.hcount <= `LPC_HCOUNT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign host_data_bus_out = s_r.dout;
  assign host_data_bus_oe = host_rd && register_select;
  assign busy = exec_busy;
  assign pixel_out = s_r.pix;
  assign hcount_m1 = s_r.regs.hcount[6:0];
  assign tdiv_m1 = s_r.regs.tdiv[6:0];
  assign start_addr = graphic_mode ? s_r.regs.start_addr :
    {4'h0, s_r.regs.start_addr[11:0]};
  assign cursor_addr = s_r.regs.cursor_addr;

  localparam int BUSY_LAST = EXEC_CYC;

  sequence s_code_wr;
    host_wr && register_select && !busy;
  endsequence : s_code_wr

  sequence s_busy_held;
    busy [*8];
  endsequence : s_busy_held

  sequence s_busy_end;
    busy ##1 !busy;
  endsequence : s_busy_end

  AST_BUSY_AFTER_PARAM: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_exec |=> busy)
    else $error("busy not raised");

  AST_BUSY_HOLDS: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_exec |=> s_busy_held)
    else $error("busy too short");

  AST_BUSY_WINDOW: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_exec |-> ##BUSY_LAST s_busy_end)
    else $error("busy window length wrong");

  AST_EXEC_STATE: assert property (
    @(posedge ref_clk) disable iff (rst)
    busy |-> s_r.st == LPC_EXEC)
    else $error("busy outside exec state");

  AST_CODE_LOAD: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_code_wr |=> s_r.code == $past(host_data_bus_in))
    else $error("code not stored");

  AST_CODE_IGNORED: assert property (
    @(posedge ref_clk) disable iff (rst)
    busy && host_wr && register_select |=> $stable(s_r.code))
    else $error("code taken while busy");

  AST_PARAM_IGNORED: assert property (
    @(posedge ref_clk) disable iff (rst)
    busy && host_wr && !register_select |=> $stable(s_r.regs))
    else $error("parameter taken while busy");

  AST_HCOUNT: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_exec && s_r.code == `LPC_CODE_HCOUNT |=> hcount_m1 == $past(host_data_bus_in[6:0]))
    else $error("hcount wrong");

  AST_HCOUNT_HOLD: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(start_exec && s_r.code == `LPC_CODE_HCOUNT) |=> $stable(hcount_m1))
    else $error("hcount changed");

  AST_TDIV: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_exec && s_r.code == `LPC_CODE_TDIV |=> tdiv_m1 == $past(host_data_bus_in[6:0]))
    else $error("tdiv wrong");

  AST_TDIV_HOLD: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(start_exec && s_r.code == `LPC_CODE_TDIV) |=> $stable(tdiv_m1))
    else $error("tdiv changed");

  AST_CLINE: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_exec && s_r.code == `LPC_CODE_CLINE |=>
    s_r.regs.cline == {4'h0, $past(host_data_bus_in[3:0])})
    else $error("cline wrong");

  AST_CLINE_HOLD: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(start_exec && s_r.code == `LPC_CODE_CLINE) |=> $stable(s_r.regs.cline))
    else $error("cline changed");

  AST_START_LO: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_exec && s_r.code == `LPC_CODE_START_LO |=>
    s_r.regs.start_addr[7:0] == $past(host_data_bus_in))
    else $error("start low wrong");

  AST_START_HI: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_exec && s_r.code == `LPC_CODE_START_HI |=>
    s_r.regs.start_addr[15:8] == $past(host_data_bus_in))
    else $error("start high wrong");

  AST_START_HOLD: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(start_exec && (s_r.code == `LPC_CODE_START_LO || s_r.code == `LPC_CODE_START_HI)) |=>
    $stable(s_r.regs.start_addr))
    else $error("start changed");

  AST_START_CHAR: assert property (
    @(posedge ref_clk) disable iff (rst)
    !graphic_mode |-> start_addr == {4'h0, s_r.regs.start_addr[11:0]})
    else $error("start wrong in character mode");

  AST_START_GFX: assert property (
    @(posedge ref_clk) disable iff (rst)
    graphic_mode |-> start_addr == s_r.regs.start_addr)
    else $error("start wrong in graphic mode");

  AST_CUR_LO: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_exec && s_r.code == `LPC_CODE_CUR_LO |=> cursor_addr[7:0] == $past(host_data_bus_in))
    else $error("cursor low wrong");

  AST_CUR_HI: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_exec && s_r.code == `LPC_CODE_CUR_HI |=> cursor_addr[15:8] == $past(host_data_bus_in))
    else $error("cursor high wrong");

  AST_CARRY: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_exec && s_r.code == `LPC_CODE_CUR_LO && carry8 |=>
    cursor_addr[15:8] == $past(s_r.regs.cursor_addr[15:8]) + 8'h01)
    else $error("carry lost");

  AST_NO_CARRY: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_exec && s_r.code == `LPC_CODE_CUR_LO && !carry8 |=> $stable(cursor_addr[15:8]))
    else $error("spurious carry");

  AST_CUR_INC: assert property (
    @(posedge ref_clk) disable iff (rst)
    cursor_inc && !busy && !start_exec |=> cursor_addr == $past(cursor_addr) + 16'h0001)
    else $error("cursor not incremented");

  AST_INC_BUSY: assert property (
    @(posedge ref_clk) disable iff (rst)
    cursor_inc && busy |=> $stable(cursor_addr))
    else $error("cursor moved while busy");

  AST_CURSOR_PRIO: assert property (
    @(posedge ref_clk) disable iff (rst)
    cursor_draw |=> pixel_out)
    else $error("cursor dot lost");

  AST_CURSOR_OFF: assert property (
    @(posedge ref_clk) disable iff (rst)
    !cursor_on |=> pixel_out == $past(char_dot))
    else $error("cursor shown while off");

  AST_GFX_NO_CURSOR: assert property (
    @(posedge ref_clk) disable iff (rst)
    graphic_mode |=> pixel_out == $past(char_dot))
    else $error("cursor shown in graphic mode");

  AST_NO_CURSOR: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_r.regs.cline[3:0] > vpitch_m1 |=> pixel_out == $past(char_dot))
    else $error("cursor shown");

  AST_BUSY_READ: assert property (
    @(posedge ref_clk) disable iff (rst)
    host_data_bus_oe |=> host_data_bus_out == {$past(busy), 7'h00})
    else $error("busy bit wrong on bus");
endmodule : lpc_cmd

// ### core/lpc_exec_timer.sv
`include "lpc_params.svh"
module lpc_exec_timer import lpc_pkg::*; #(
  parameter int CYCLES = `LPC_EXEC_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  output logic busy
);
  typedef struct packed {
    logic [15:0] cnt;
  } lpc_tmr_state_t;
  lpc_tmr_state_t s_r;
  lpc_tmr_state_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (start) begin
      s_nxt.cnt = 16'(CYCLES);
    end else if (s_r.cnt != 16'h0000) begin
      s_nxt.cnt = s_r.cnt - 16'h0001;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign busy = (s_r.cnt != 16'h0000);
endmodule : lpc_exec_timer

// ### core/lpc_params.svh
`ifndef LPC_PARAMS_SVH
`define LPC_PARAMS_SVH
`define LPC_CODE_HCOUNT 8'h02
`define LPC_CODE_TDIV 8'h03
`define LPC_CODE_CLINE 8'h04
`define LPC_CODE_START_LO 8'h08
`define LPC_CODE_START_HI 8'h09
`define LPC_CODE_CUR_LO 8'h0A
`define LPC_CODE_CUR_HI 8'h0B
`define LPC_CLK_MHZ 25
`define LPC_EXEC_NS 4000
`define LPC_CLK_NS 40
`define LPC_EXEC_CYC ((`LPC_EXEC_NS + `LPC_CLK_NS - 1) / `LPC_CLK_NS)
`define LPC_HCOUNT_RST 8'h01
`define LPC_TDIV_RST 8'h00
`define LPC_CLINE_RST 8'h00
`define LPC_BUSY_BIT 7
`endif

// ### core/lpc_pkg.sv
package lpc_pkg;
  typedef enum logic [1:0] {
    LPC_IDLE = 2'b00,
    LPC_CODE = 2'b01,
    LPC_EXEC = 2'b11
  } lpc_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic register_select;
    logic [7:0] data;
  } lpc_host_t;
  typedef struct packed {
    logic [7:0] hcount;
    logic [7:0] tdiv;
    logic [7:0] cline;
    logic [15:0] start_addr;
    logic [15:0] cursor_addr;
  } lpc_regs_t;
endpackage : lpc_pkg

// ### tb/lpc_host_model.sv
module lpc_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] host_data_bus_out,
  output logic register_select,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_data_bus_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    register_select = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_data_bus_in = 8'hA5;
  end
  // one write strobe, released bus shows inverse data
  task automatic wr(input logic rs, input logic [7:0] d);
    @(posedge ref_clk);
    register_select <= rs;
    host_data_bus_in <= d;
    host_wr <= 1'b1;
    @(posedge ref_clk);
    host_wr <= 1'b0;
    host_data_bus_in <= ~d;
  endtask : wr
  // wait for busy bit low on the bus
  task automatic poll();
    @(posedge ref_clk);
    register_select <= 1'b1;
    host_rd <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    while (host_data_bus_out[7] !== 1'b0) @(negedge ref_clk);
    @(posedge ref_clk);
    host_rd <= 1'b0;
  endtask : poll
  task automatic instr(input logic [7:0] code, input logic [7:0] p);
    wr(1'b1, code);
    wr(1'b0, p);
    poll();
  endtask : instr
endmodule : lpc_host_model

// ### tb/tb_lcd_param_cursor_cmds.sv
module tb_lcd_param_cursor_cmds;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EXEC = 10;
  logic ref_clk = 0, rst = 1, rs, wr, rd, oe, gm = 0, con = 0, cinc = 0, cdot = 0, pix, busy;
  logic [7:0] din, dout, lo, hi;
  logic [2:0] hp = 0, rdot = 0;
  logic [3:0] vp = 0, rline = 0;
  logic [15:0] raddr = 0, sa, ca, cold;
  logic [6:0] hc, td, lh;
  int err_total = 0, checks = 0, seed = 32'h02FFA806, n, i;
  always #20 ref_clk = ~ref_clk;
  lpc_host_model h (.ref_clk(ref_clk), .host_data_bus_out(dout), .register_select(rs),
    .host_wr(wr), .host_rd(rd), .host_data_bus_in(din));
  lpc_cmd #(.EXEC_CYC(EXEC)) dut (.ref_clk(ref_clk), .rst(rst), .register_select(rs),
    .host_wr(wr), .host_rd(rd), .host_data_bus_in(din), .host_data_bus_out(dout),
    .host_data_bus_oe(oe), .graphic_mode(gm), .cursor_on(con), .hpitch_m1(hp),
    .vpitch_m1(vp), .cursor_inc(cinc), .refresh_addr(raddr), .refresh_line(rline),
    .refresh_dot(rdot), .char_dot(cdot), .pixel_out(pix), .hcount_m1(hc), .tdiv_m1(td),
    .start_addr(sa), .cursor_addr(ca), .busy(busy));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [15:0] exp_lo(input logic [15:0] old, input logic [7:0] nlo);
    exp_lo = {old[15:8] + {7'h00, old[7] && !nlo[7]}, nlo};
  endfunction : exp_lo
  function automatic logic [15:0] exp_start(input logic g, input logic [7:0] shi,
    input logic [7:0] slo);
    exp_start = g ? {shi, slo} : {4'h0, shi[3:0], slo};
  endfunction : exp_start
  task automatic print_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #2000000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("hcount", 16'h0001, 16'(hc));
    chk("tdiv", 16'h0000, 16'(td));
    chk("cursor", 16'h0000, ca);
    chk("oe", 16'h0000, 16'(oe));
    fork
      h.poll();
      begin
        repeat (2) @(negedge ref_clk);
        chk("oe", 16'h0001, 16'(oe));
      end
    join
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      n = 2 * (1 + ($random(seed) & 63));
      h.instr(8'h02, 8'(n - 1));
      chk("hcount", 16'(n - 1), 16'(hc));
      n = 1 + ($random(seed) & 127);
      h.instr(8'h03, 8'(n - 1));
      chk("tdiv", 16'(n - 1), 16'(td));
    end
    lh = hc;
    $display("test params done");
    h.wr(1'b1, 8'h03);
    h.wr(1'b0, 8'h11);
    @(negedge ref_clk);
    chk("busy", 16'h0001, 16'(busy));
    @(posedge ref_clk) cinc <= 1'b1;
    @(posedge ref_clk) cinc <= 1'b0;
    repeat (EXEC - 3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("busy", 16'h0001, 16'(busy));
    chk("cursor", 16'h0000, ca);
    @(negedge ref_clk);
    chk("busy", 16'h0000, 16'(busy));
    h.wr(1'b0, 8'h33);
    h.wr(1'b1, 8'h02);
    h.wr(1'b0, 8'h44);
    h.poll();
    chk("tdiv", 16'h0033, 16'(td));
    chk("hcount", 16'(lh), 16'(hc));
    $display("test busy done");
    h.instr(8'h0A, 8'h80);
    h.instr(8'h0B, 8'h12);
    h.instr(8'h0A, 8'h05);
    chk("cursor", 16'h1305, ca);
    h.instr(8'h0B, 8'h12);
    chk("cursor", 16'h1205, ca);
    h.instr(8'h0A, 8'hFF);
    h.instr(8'h0B, 8'h13);
    @(posedge ref_clk) cinc <= 1'b1;
    @(posedge ref_clk) cinc <= 1'b0;
    @(negedge ref_clk);
    chk("cursor", 16'h1400, ca);
    for (i = 0; i < 4; i++) begin
      cold = ca;
      lo = 8'($random(seed));
      h.instr(8'h0A, lo);
      chk("cursor", exp_lo(cold, lo), ca);
      h.instr(8'h0B, cold[15:8]);
      chk("cursor", {cold[15:8], lo}, ca);
    end
    $display("test cursor done");
    lo = 8'($random(seed));
    hi = 8'($random(seed)) | 8'hF0;
    h.instr(8'h08, lo);
    h.instr(8'h09, hi);
    @(posedge ref_clk) gm <= 1'b1;
    @(negedge ref_clk);
    chk("start", exp_start(1'b1, hi, lo), sa);
    @(posedge ref_clk) gm <= 1'b0;
    @(negedge ref_clk);
    chk("start", exp_start(1'b0, hi, lo), sa);
    $display("test start done");
    h.instr(8'h04, 8'h02);
    @(posedge ref_clk);
    {raddr, vp, hp, con, rline, rdot, cdot} <= {ca, 4'hF, 3'h7, 1'b1, 4'h2, 3'h0, 1'b1};
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("pixel", 16'h0001, 16'(pix));
    @(posedge ref_clk) {vp, cdot} <= {4'h1, 1'b0};
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("pixel", 16'h0000, 16'(pix));
    $display("test pixel done");
    print_verdict();
  end
endmodule : tb_lcd_param_cursor_cmds
